//--- include/csrc_defs.vh
`ifndef CSRC_DEFS_VH
`define CSRC_DEFS_VH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define CSRC_IDX_HOP_INDEX      6'h0a
`define CSRC_IDX_CARRIER_HIGH   6'h0d
`define CSRC_IDX_CARRIER_MID    6'h0e
`define CSRC_IDX_CARRIER_LOW    6'h0f
`define CSRC_IDX_RATE_EXPONENT  6'h10
`define CSRC_IDX_RATE_MANTISSA  6'h11
`define CSRC_IDX_CARRIER_RESULT 6'h18
`define CSRC_IDX_RATE_RESULT    6'h19
`define CSRC_IDX_STATUS         6'h1a

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CSRC_HIGH_FIELD_MSB     5
`define CSRC_EXP_FIELD_MSB      3
`define CSRC_STATUS_BUSY_BIT    0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CSRC_RST_HOP_INDEX      8'h00
`define CSRC_RST_CARRIER_HIGH   6'h1e
`define CSRC_RST_CARRIER_MID    8'hc4
`define CSRC_RST_CARRIER_LOW    8'hec
`define CSRC_RST_RATE_EXPONENT  4'hc
`define CSRC_RST_RATE_MANTISSA  8'h22

// ---------------------------------------------------------------
// Arithmetic constants
// ---------------------------------------------------------------
`define CSRC_MANTISSA_HIDDEN    9'h100
`define CSRC_RATE_ACC_BITS      28
`define CSRC_SPACING_FRAC_BITS  2

`endif

//--- rtl/csrc_symbol_nco.v
`timescale 1ns/1ps
`include "csrc_defs.vh"

module csrc_symbol_nco #(
  parameter ACC_W = `CSRC_RATE_ACC_BITS
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Rate setting
  input  wire [3:0]       i_exponent,
  input  wire [7:0]       i_mantissa,
  // Results
  output reg  [23:0]      o_rate_word,
  output reg              o_symbol_tick
);

  // ---------------------------------------------------------------
  // Rate word and accumulator
  // ---------------------------------------------------------------
  reg  [ACC_W-1:0] acc;
  wire [8:0]       full_mantissa;
  wire [23:0]      rate_word;
  wire [ACC_W:0]   next_acc;

  assign full_mantissa = `CSRC_MANTISSA_HIDDEN | {1'b0, i_mantissa};
  assign rate_word     = {15'h0000, full_mantissa} << i_exponent;
  assign next_acc      = {1'b0, acc} + {{(ACC_W-23){1'b0}}, rate_word};

  // Carry out of a 2^28 accumulator clocked from the crystal gives the rate
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc           <= {ACC_W{1'b0}};
      o_rate_word   <= 24'h000000;
      o_symbol_tick <= 1'b0;
    end else begin
      acc           <= next_acc[ACC_W-1:0];
      o_rate_word   <= rate_word;
      o_symbol_tick <= next_acc[ACC_W];
    end
  end

endmodule // csrc_symbol_nco

//--- rtl/csrc_top.v
`timescale 1ns/1ps
`include "csrc_defs.vh"


module csrc_top #(
  parameter SPACING_W = 16,
  parameter CARRIER_W = 27
) (
  // Clock and reset
  input  wire                 i_clk,
  input  wire                 i_rst_n,
  // Wishbone slave
  input  wire                 i_wb_cyc,
  input  wire                 i_wb_stb,
  input  wire                 i_wb_we,
  input  wire [7:0]           i_wb_adr,
  input  wire [3:0]           i_wb_sel,
  input  wire [31:0]          i_wb_dat,
  output reg  [31:0]          o_wb_dat,
  output reg                  o_wb_ack,
  // Channel spacing from the modulator configuration
  input  wire [SPACING_W-1:0] i_hop_index_spacing,
  // Derived settings
  output reg  [CARRIER_W-1:0] o_carrier_word,
  output reg                  o_carrier_valid,
  output reg  [23:0]          o_symbol_rate_word,
  output reg                  o_symbol_tick,
  output reg  [7:0]           o_hop_index,
  output reg  [3:0]           o_symbol_rate_exponent,
  output reg  [7:0]           o_symbol_rate_mantissa
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_MUL  = 1'b1;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  reg  [7:0]           hop_index_reg;
  reg  [5:0]           carrier_word_high;
  reg  [7:0]           carrier_word_mid;
  reg  [7:0]           carrier_word_low;
  reg  [3:0]           symbol_rate_exponent;
  reg  [7:0]           symbol_rate_mantissa;

  wire [23:0]          carrier_word;
  wire [5:0]           reg_index;
  wire                 bus_req;
  wire                 wr_en;
  wire                 carrier_cfg_wr;

  assign carrier_word   = {2'b00, carrier_word_high, carrier_word_mid, carrier_word_low};
  assign reg_index      = i_wb_adr[7:2];
  assign bus_req        = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Single-cycle write strobe; only the low byte lane carries data
  assign wr_en          = bus_req & i_wb_we & i_wb_sel[0];
  assign carrier_cfg_wr = wr_en & ((reg_index == `CSRC_IDX_HOP_INDEX) |
                                   (reg_index == `CSRC_IDX_CARRIER_HIGH) |
                                   (reg_index == `CSRC_IDX_CARRIER_MID) |
                                   (reg_index == `CSRC_IDX_CARRIER_LOW));

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      hop_index_reg        <= `CSRC_RST_HOP_INDEX;
      carrier_word_high    <= `CSRC_RST_CARRIER_HIGH;
      carrier_word_mid     <= `CSRC_RST_CARRIER_MID;
      carrier_word_low     <= `CSRC_RST_CARRIER_LOW;
      symbol_rate_exponent <= `CSRC_RST_RATE_EXPONENT;
      symbol_rate_mantissa <= `CSRC_RST_RATE_MANTISSA;
    end else if (wr_en) begin
      case (reg_index)
        `CSRC_IDX_HOP_INDEX: begin
          hop_index_reg <= i_wb_dat[7:0];
        end
        `CSRC_IDX_CARRIER_HIGH: begin
          // Top two bits have no storage at all
          carrier_word_high <= i_wb_dat[`CSRC_HIGH_FIELD_MSB:0];
        end
        `CSRC_IDX_CARRIER_MID: begin
          carrier_word_mid <= i_wb_dat[7:0];
        end
        `CSRC_IDX_CARRIER_LOW: begin
          carrier_word_low <= i_wb_dat[7:0];
        end
        `CSRC_IDX_RATE_EXPONENT: begin
          symbol_rate_exponent <= i_wb_dat[`CSRC_EXP_FIELD_MSB:0];
        end
        `CSRC_IDX_RATE_MANTISSA: begin
          symbol_rate_mantissa <= i_wb_dat[7:0];
        end
        default: begin
          hop_index_reg <= hop_index_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Carrier computation
  // ---------------------------------------------------------------
  // Shift-add over eight cycles; a single multiplier would cost more area
  // than the settling time of the synthesizer could ever justify.
  reg                  state;
  reg                  dirty;
  reg  [7:0]           mul_index;
  reg  [23:0]          mul_spacing;
  reg  [SPACING_W-1:0] spacing_snap;
  reg  [CARRIER_W-1:0] mul_acc;
  reg  [2:0]           mul_cnt;

  reg                  next_state;
  reg                  next_dirty;
  reg  [7:0]           next_mul_index;
  reg  [23:0]          next_mul_spacing;
  reg  [SPACING_W-1:0] next_spacing_snap;
  reg  [CARRIER_W-1:0] next_mul_acc;
  reg  [2:0]           next_mul_cnt;
  reg  [CARRIER_W-1:0] next_carrier_word;
  reg                  next_carrier_valid;

  wire                 spacing_moved;
  wire                 start;
  wire [CARRIER_W-1:0] base_scaled;
  wire [CARRIER_W-1:0] addend;

  assign spacing_moved = (i_hop_index_spacing != spacing_snap);
  assign start         = (state == ST_IDLE) & (dirty | spacing_moved);
  // Base word aligned to the finer spacing resolution
  assign base_scaled   = {{(CARRIER_W-24-`CSRC_SPACING_FRAC_BITS){1'b0}}, carrier_word,
                          {`CSRC_SPACING_FRAC_BITS{1'b0}}};
  assign addend        = {{(CARRIER_W-24){1'b0}}, mul_spacing};

  always @* begin
    next_state         = state;
    next_mul_index     = mul_index;
    next_mul_spacing   = mul_spacing;
    next_spacing_snap  = spacing_snap;
    next_mul_acc       = mul_acc;
    next_mul_cnt       = mul_cnt;
    next_carrier_word  = o_carrier_word;
    next_carrier_valid = o_carrier_valid;
    // A write landing on the start cycle stays pending
    next_dirty         = carrier_cfg_wr | (dirty & ~start);
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state         = ST_MUL;
          next_mul_index     = hop_index_reg;
          next_spacing_snap  = i_hop_index_spacing;
          next_mul_spacing   = {{(24-SPACING_W){1'b0}}, i_hop_index_spacing};
          next_mul_acc       = base_scaled;
          next_mul_cnt       = 3'h0;
          next_carrier_valid = 1'b0;
        end
      end
      ST_MUL: begin
        if (mul_index[0]) begin
          next_mul_acc = mul_acc + addend;
        end
        next_mul_index   = {1'b0, mul_index[7:1]};
        next_mul_spacing = {mul_spacing[22:0], 1'b0};
        next_mul_cnt     = mul_cnt + 3'h1;
        if (mul_cnt == 3'h7) begin
          next_state         = ST_IDLE;
          next_carrier_word  = mul_index[0] ? (mul_acc + addend) : mul_acc;
          next_carrier_valid = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state           <= ST_IDLE;
      dirty           <= 1'b1;
      mul_index       <= 8'h00;
      mul_spacing     <= 24'h000000;
      spacing_snap    <= {SPACING_W{1'b0}};
      mul_acc         <= {CARRIER_W{1'b0}};
      mul_cnt         <= 3'h0;
      o_carrier_word  <= {CARRIER_W{1'b0}};
      o_carrier_valid <= 1'b0;
    end else begin
      state           <= next_state;
      dirty           <= next_dirty;
      mul_index       <= next_mul_index;
      mul_spacing     <= next_mul_spacing;
      spacing_snap    <= next_spacing_snap;
      mul_acc         <= next_mul_acc;
      mul_cnt         <= next_mul_cnt;
      o_carrier_word  <= next_carrier_word;
      o_carrier_valid <= next_carrier_valid;
    end
  end

  // ---------------------------------------------------------------
  // Symbol rate generator
  // ---------------------------------------------------------------
  wire [23:0] nco_rate_word;
  wire        nco_tick;

  csrc_symbol_nco #(
    .ACC_W (`CSRC_RATE_ACC_BITS)
  ) u_nco (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_exponent    (symbol_rate_exponent),
    .i_mantissa    (symbol_rate_mantissa),
    .o_rate_word   (nco_rate_word),
    .o_symbol_tick (nco_tick)
  );

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_symbol_rate_word     <= 24'h000000;
      o_symbol_tick          <= 1'b0;
      o_hop_index            <= 8'h00;
      o_symbol_rate_exponent <= 4'h0;
      o_symbol_rate_mantissa <= 8'h00;
    end else begin
      o_symbol_rate_word     <= nco_rate_word;
      o_symbol_tick          <= nco_tick;
      o_hop_index            <= hop_index_reg;
      o_symbol_rate_exponent <= symbol_rate_exponent;
      o_symbol_rate_mantissa <= symbol_rate_mantissa;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  reg [31:0] next_rd_data;

  always @* begin
    next_rd_data = 32'h00000000;
    case (reg_index)
      `CSRC_IDX_HOP_INDEX: begin
        next_rd_data = {24'h000000, hop_index_reg};
      end
      `CSRC_IDX_CARRIER_HIGH: begin
        next_rd_data = {24'h000000, 2'b00, carrier_word_high};
      end
      `CSRC_IDX_CARRIER_MID: begin
        next_rd_data = {24'h000000, carrier_word_mid};
      end
      `CSRC_IDX_CARRIER_LOW: begin
        next_rd_data = {24'h000000, carrier_word_low};
      end
      `CSRC_IDX_RATE_EXPONENT: begin
        next_rd_data = {24'h000000, 4'h0, symbol_rate_exponent};
      end
      `CSRC_IDX_RATE_MANTISSA: begin
        next_rd_data = {24'h000000, symbol_rate_mantissa};
      end
      `CSRC_IDX_CARRIER_RESULT: begin
        next_rd_data = {{(32-CARRIER_W){1'b0}}, o_carrier_word};
      end
      `CSRC_IDX_RATE_RESULT: begin
        next_rd_data = {8'h00, nco_rate_word};
      end
      `CSRC_IDX_STATUS: begin
        next_rd_data = {31'h00000000, (state == ST_MUL) | dirty};
      end
      default: begin
        // Unmapped words answer with zero
        next_rd_data = 32'h00000000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  // Every access, mapped or not, is acknowledged one cycle later so a stray
  // address never hangs the master.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req) begin
        o_wb_dat <= next_rd_data;
      end
    end
  end

endmodule // csrc_top

//--- verif/csrc_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Checker on the top ports
// ----------------------------------------
module csrc_top_asserts #(
  parameter SPACING_W = 16,
  parameter CARRIER_W = 27
) (
  input logic                 i_clk,
  input logic                 i_rst_n,
  input logic                 i_wb_cyc,
  input logic                 i_wb_stb,
  input logic                 i_wb_we,
  input logic [7:0]           i_wb_adr,
  input logic [31:0]          o_wb_dat,
  input logic                 o_wb_ack,
  input logic [SPACING_W-1:0] i_hop_index_spacing,
  input logic [CARRIER_W-1:0] o_carrier_word,
  input logic                 o_carrier_valid,
  input logic [23:0]          o_symbol_rate_word,
  input logic                 o_symbol_tick,
  input logic [3:0]           o_symbol_rate_exponent,
  input logic [7:0]           o_symbol_rate_mantissa
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Rate word only judged once the setting has settled, since it lags the copies
  logic [1:0] st;
  logic [3:0] pe;
  logic [7:0] pm;
  always @(posedge i_clk) begin
    pe <= o_symbol_rate_exponent;
    pm <= o_symbol_rate_mantissa;
    if (!i_rst_n || pe != o_symbol_rate_exponent || pm != o_symbol_rate_mantissa) st <= 2'd0;
    else if (st != 2'd3) st <= st + 2'd1;
  end
  a_ack_taken: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not acked");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  a_high_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] == 6'h0d |-> o_wb_dat[7:6] == 2'b00)
    else $error("high carrier byte top bits set");
  a_exp_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] == 6'h10 |-> o_wb_dat[7:4] == 4'h0)
    else $error("exponent reserved bits set");
  // Rate word trails the register copies by one more cycle, so judge it against the held copies
  a_rate_word: assert property (st == 2'd3 |->
    o_symbol_rate_word == ((24'd256 + {16'h0, pm}) << pe))
    else $error("rate word wrong");
  a_compute_len: assert property ($fell(o_carrier_valid) |-> (!o_carrier_valid)[*8] ##1 o_carrier_valid)
    else $error("carrier compute length wrong");
  a_word_hold: assert property (o_carrier_valid && $past(o_carrier_valid) |-> $stable(o_carrier_word))
    else $error("carrier word moved while valid");
  a_spacing_restart: assert property (o_carrier_valid && i_hop_index_spacing != $past(i_hop_index_spacing)
    |-> ##[1:3] !o_carrier_valid) else $error("spacing change ignored");
  a_tick_pulse: assert property (o_symbol_tick |=> !o_symbol_tick) else $error("tick too wide");
  c_compute: cover property ($rose(o_carrier_valid));
  c_tick: cover property (o_symbol_tick);
  c_write: cover property (o_wb_ack && i_wb_we);
endmodule // csrc_top_asserts

bind csrc_top csrc_top_asserts #(.SPACING_W(SPACING_W), .CARRIER_W(CARRIER_W)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_hop_index_spacing(i_hop_index_spacing),
  .o_carrier_word(o_carrier_word), .o_carrier_valid(o_carrier_valid), .o_symbol_rate_word(o_symbol_rate_word),
  .o_symbol_tick(o_symbol_tick), .o_symbol_rate_exponent(o_symbol_rate_exponent),
  .o_symbol_rate_mantissa(o_symbol_rate_mantissa));

//--- verif/tb.sv
`timescale 1ns/1ps
`include "csrc_defs.vh"
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  logic        i_clk = 0;
  logic        i_rst_n = 0;
  logic        i_wb_cyc = 0;
  logic        i_wb_stb = 0;
  logic        i_wb_we = 0;
  logic [7:0]  i_wb_adr = 0;
  logic [3:0]  i_wb_sel = 0;
  logic [31:0] i_wb_dat = 0;
  logic [15:0] i_hop_index_spacing = 16'h0010;
  wire  [31:0] o_wb_dat;
  wire         o_wb_ack;
  wire  [26:0] o_carrier_word;
  wire         o_carrier_valid;
  wire  [23:0] o_symbol_rate_word;
  wire         o_symbol_tick;
  wire  [7:0]  o_hop_index;
  wire  [3:0]  o_symbol_rate_exponent;
  wire  [7:0]  o_symbol_rate_mantissa;
  int          failures = 0;
  int          n_tests = 0;
  int          ticks = 0;
  int          t0;
  longint      n_exp;
  logic [31:0] q[$];
  logic [7:0]  lf = 8'h60;
  logic [7:0]  r [0:5] = '{8'h00, 8'h1e, 8'hc4, 8'hec, 8'h0c, 8'h22};
  logic [5:0]  idx [0:5] = '{`CSRC_IDX_HOP_INDEX, `CSRC_IDX_CARRIER_HIGH, `CSRC_IDX_CARRIER_MID,
                             `CSRC_IDX_CARRIER_LOW, `CSRC_IDX_RATE_EXPONENT, `CSRC_IDX_RATE_MANTISSA};
  always #12.5 i_clk = ~i_clk;
  csrc_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_hop_index_spacing(i_hop_index_spacing), .o_carrier_word(o_carrier_word), .o_carrier_valid(o_carrier_valid),
    .o_symbol_rate_word(o_symbol_rate_word), .o_symbol_tick(o_symbol_tick), .o_hop_index(o_hop_index),
    .o_symbol_rate_exponent(o_symbol_rate_exponent), .o_symbol_rate_mantissa(o_symbol_rate_mantissa));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Master waits on ack with a bound rather than assuming the one-cycle answer
  task wb(input logic we, input logic [5:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {a, 2'b00};
    i_wb_sel <= s;
    i_wb_dat <= {24'h0, d};
    n = 0;
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 20) failures++;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task wait_valid;
    int n;
    repeat (3) @(posedge i_clk);
    n = 0;
    while (o_carrier_valid !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 50) failures++;
  endtask
  task wr(input int i, input logic [7:0] d);
    wb(1'b1, idx[i], d, 4'h1);
    r[i] = d & (i == 1 ? 8'h3f : i == 4 ? 8'h0f : 8'hff);
    wait_valid;
  endtask
  task rd_all;
    for (int i = 0; i < 6; i++) begin
      q.push_back({24'h0, r[i]});
      wb(1'b0, idx[i], 8'h00, 4'hf);
    end
  endtask
  task chk_out;
    check({5'h0, o_carrier_word}, ({10'h0, r[1][5:0], r[2], r[3]} << 2) + r[0] * i_hop_index_spacing);
    check({8'h0, o_symbol_rate_word}, (32'd256 + r[5]) << r[4][3:0]);
    check({24'h0, o_hop_index}, {24'h0, r[0]});
    check({28'h0, o_symbol_rate_exponent}, {28'h0, r[4][3:0]});
    check({24'h0, o_symbol_rate_mantissa}, {24'h0, r[5]});
  endtask
  // ----------------------------------------
  // Sequence and result monitor
  // ----------------------------------------
  always @(posedge i_clk)
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) check(o_wb_dat, q.size() ? q.pop_front() : 32'hffffffff);
  always @(posedge i_clk)
    if (o_symbol_tick === 1'b1) ticks++;
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_valid;
    rd_all;
    chk_out;
    // Tick count over a fixed span; the accumulator phase allows one extra tick above the expected count
    t0 = ticks;
    repeat (2048) @(posedge i_clk);
    n_exp = (64'd2048 * ((64'd256 + 64'h22) << 12)) >> 28;
    check(((ticks - t0) == n_exp) || ((ticks - t0) == n_exp + 1), 32'h1);
    q.push_back(32'h0);
    wb(1'b0, `CSRC_IDX_STATUS, 8'h00, 4'hf);
    q.push_back(32'h0);
    wb(1'b0, 6'h3f, 8'h00, 4'hf);
    wr(1, 8'hff);
    wr(4, 8'hff);
    wb(1'b1, idx[2], 8'h55, 4'he);
    rd_all;
    for (int k = 0; k < 4; k++) begin
      i_hop_index_spacing <= {rnd(), rnd()};
      wait_valid;
      chk_out;
      wr(0, rnd());
      wr(1, 8'h0a + rnd() % 25);
      wr(2, rnd());
      wr(3, rnd());
      wr(4, rnd());
      wr(5, rnd());
      chk_out;
      rd_all;
    end
    test_done;
  end
endmodule // tb
